// ### include/kms_pkg.sv
// keyboard matrix scanner: shared addresses, field positions, reset values
// assumes a 100 MHz system clock and the 24-pin general-purpose pin set

package kms_pkg;

    // ********************************************************
    // pin set
    // ********************************************************
    localparam int NUM_PINS = 24;
    localparam int GROUP_WIDTH = 8;
    localparam int NUM_GROUPS = 3;

    // ********************************************************
    // register addresses (I/O space and index space)
    // ********************************************************
    localparam logic [7:0] ADDR_KBD_DATA = 8'h60;
    localparam logic [7:0] ADDR_KBD_CTRL = 8'h61;
    localparam logic [7:0] ADDR_KBD_AUX = 8'h62;
    localparam logic [7:0] IDX_SCAN_ENABLE = 8'h66;
    localparam logic [7:0] IDX_NMI_CTRL_STAT = 8'h67;
    localparam logic [7:0] IDX_DRIVE_BASE = 8'h69;
    localparam logic [7:0] IDX_SENSE_BASE = 8'h6C;
    localparam logic [7:0] IDX_TIMER_PERIOD = 8'h6F;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int MODE_SELECT_BIT = 2;
    localparam int PRIMARY_SELECT_BIT = 3;
    localparam int KEY_NMI_EN_BIT = 0;
    localparam int TIMER_EN_BIT = 1;
    localparam int KEY_NMI_STS_BIT = 4;
    localparam int TIMER_NMI_STS_BIT = 5;
    localparam int KBD_IRQ_CLEAR_BIT = 7;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0] SCAN_ENABLE_RST = 8'h00;
    localparam logic [7:0] KBD_CTRL_RST = 8'h00;
    localparam logic [7:0] KBD_DATA_RST = 8'h00;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    localparam logic [7:0] TIMER_PERIOD_RST = 8'h09;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMER_TICK_NS = 1000000;
    localparam int TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;

endpackage

// ### tb/kms_matrix_model.sv
// keyboard matrix scanner bench: switch matrix with pull resistors on the pins
// assumes one key at a time; return pins pulled up, scan pins pulled down weakly

`timescale 1ns/1ps

module kms_matrix_model (
    input wire logic [23:0] pinOut,
    input wire logic [23:0] pinOeN,
    input wire logic [23:0] scanSel,
    input wire logic [23:0] returnSel,
    input wire logic keyDown,
    input wire logic [4:0] keyScan,
    input wire logic [4:0] keyRet,
    output logic [23:0] pinLevel
);
    // ************************************************************
    // pin resolution
    // ************************************************************
    logic scanLow;

    assign scanLow = !pinOeN[keyScan] && !pinOut[keyScan];

    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (!pinOeN[i]) begin
                pinLevel[i] = pinOut[i];
            end else if (scanSel[i]) begin
                // floating scan line: divider pulls it high only through a closed key
                pinLevel[i] = keyDown && (keyScan == 5'(i));
            end else if (returnSel[i]) begin
                pinLevel[i] = !(keyDown && (keyRet == 5'(i)) && scanLow);
            end else begin
                pinLevel[i] = 1'b1;
            end
        end
    end
endmodule // kms_matrix_model

// ### tb/testbench.sv
// keyboard matrix scanner bench: register port tasks and one task per scenario
// assumes kms_top with a shortened timer tick and the matrix model on the pins

`timescale 1ns/1ps

module testbench;
    localparam int TICKS = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ioIndex = 1'b0;
    logic [7:0] ioAddr = 8'h00;
    logic [7:0] ioWrData = 8'h00;
    logic ioWr = 1'b0;
    logic ioRd = 1'b0;
    logic [7:0] ioRdData;
    logic ioRdValid;
    logic [23:0] scanSel = 24'h00FF00;
    logic [23:0] returnSel = 24'h0000FF;
    logic [23:0] pinIn;
    logic [23:0] pinOut;
    logic [23:0] pinOeN;
    logic [7:0] serialData = 8'h4D;
    logic [7:0] auxIn = 8'hC3;
    logic nmi;
    logic keyboardIrq;
    logic keyDown = 1'b0;
    logic [4:0] keyScan = 5'h00;
    logic [4:0] keyRet = 5'h00;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    kms_top #(.TICK_CYCLES(TICKS)) u_dut (.clock(clock), .rst(rst), .ioIndex(ioIndex),
        .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData),
        .ioRdValid(ioRdValid), .scanSel(scanSel), .returnSel(returnSel), .pinIn(pinIn),
        .pinOut(pinOut), .pinOeN(pinOeN), .serialData(serialData), .auxIn(auxIn),
        .nmi(nmi), .keyboardIrq(keyboardIrq));

    kms_matrix_model u_matrix (.pinOut(pinOut), .pinOeN(pinOeN), .scanSel(scanSel),
        .returnSel(returnSel), .keyDown(keyDown), .keyScan(keyScan), .keyRet(keyRet),
        .pinLevel(pinIn));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic idx, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        ioIndex <= idx;
        ioAddr <= a;
        ioWrData <= d;
        ioWr <= 1'b1;
        @(posedge clock);
        ioWr <= 1'b0;
    endtask

    // read answer stands one cycle, so it is looked at just after that edge
    task automatic rd(input logic idx, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        ioIndex <= idx;
        ioAddr <= a;
        ioRd <= 1'b1;
        @(posedge clock);
        ioRd <= 1'b0;
        #1;
        chk("read valid", 24'h000001, {23'h0, ioRdValid});
        chk("read data", {16'h0, exp}, {16'h0, ioRdData});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic waitNmi(input logic lvl, input int maxc, output int n);
        n = 0;
        while (n < maxc && nmi !== lvl) begin
            settle(1);
            n++;
        end
        chk("nmi", {23'h0, lvl}, {23'h0, nmi});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic tReset();
        chk("oe after reset", 24'hFFFFFF, pinOeN);
        chk("nmi after reset", 24'h000000, {23'h0, nmi});
        rd(1'b1, 8'h66, 8'h00);
        rd(1'b1, 8'h67, 8'h00);
        rd(1'b1, 8'h69, 8'h00);
        rd(1'b1, 8'h6F, 8'h09);
        rd(1'b1, 8'h70, 8'h00);
        rd(1'b0, 8'h62, 8'hC3);
    endtask

    task automatic tDrive();
        wr(1'b1, 8'h6A, 8'hA5);
        wr(1'b1, 8'h69, 8'hFF);
        wr(1'b1, 8'h6B, 8'h3C);
        settle(1);
        chk("oe group B only", 24'hFF5AFF, pinOeN);
        chk("pin out", 24'h000000, pinOut);
        @(posedge clock);
        scanSel <= 24'hFFFF00;
        settle(2);
        chk("oe group C added", 24'hC35AFF, pinOeN);
        @(posedge clock);
        scanSel <= 24'h00FF00;
        settle(2);
        chk("oe group C released", 24'hFF5AFF, pinOeN);
    endtask

    task automatic tSense();
        wr(1'b1, 8'h6A, 8'h02);
        keyScan <= 5'd9;
        keyRet <= 5'd3;
        keyDown <= 1'b1;
        settle(5);
        rd(1'b1, 8'h6C, 8'hF7);
        rd(1'b1, 8'h6D, 8'hFF);
        rd(1'b1, 8'h6E, 8'hFF);
        keyDown <= 1'b0;
        settle(5);
        rd(1'b1, 8'h6C, 8'hFF);
    endtask

    task automatic tKeyFull();
        int n;
        wr(1'b1, 8'h6A, 8'hFE);
        wr(1'b1, 8'h67, 8'h01);
        keyScan <= 5'd12;
        keyRet <= 5'd6;
        keyDown <= 1'b1;
        settle(8);
        chk("nmi one scan floating", 24'h000000, {23'h0, nmi});
        wr(1'b1, 8'h6A, 8'hFF);
        waitNmi(1'b1, 10, n);
        rd(1'b1, 8'h67, 8'h11);
        wr(1'b1, 8'h67, 8'h11);
        waitNmi(1'b0, 5, n);
        settle(6);
        rd(1'b1, 8'h67, 8'h01);
        keyDown <= 1'b0;
    endtask

    task automatic tPartial();
        int n;
        wr(1'b1, 8'h66, 8'h04);
        wr(1'b1, 8'h6A, 8'h00);
        settle(6);
        chk("nmi idle partial", 24'h000000, {23'h0, nmi});
        keyScan <= 5'd10;
        keyDown <= 1'b1;
        waitNmi(1'b1, 10, n);
        rd(1'b1, 8'h67, 8'h11);
        keyDown <= 1'b0;
        wr(1'b1, 8'h67, 8'h10);
        waitNmi(1'b0, 5, n);
        wr(1'b1, 8'h66, 8'h00);
    endtask

    task automatic tTimer();
        int n;
        // period 2 means three ticks of TICKS cycles, then status and nmi stages
        wr(1'b1, 8'h6F, 8'h02);
        wr(1'b1, 8'h67, 8'h02);
        waitNmi(1'b1, 40, n);
        chk("timer delay", 24'h000001, {23'h0, (n >= 3 * TICKS) && (n <= 3 * TICKS + 4)});
        rd(1'b1, 8'h67, 8'h22);
        wr(1'b1, 8'h67, 8'h20);
        waitNmi(1'b0, 5, n);
    endtask

    task automatic tData();
        wr(1'b0, 8'h60, 8'h5A);
        settle(1);
        chk("irq serial primary", 24'h000000, {23'h0, keyboardIrq});
        rd(1'b0, 8'h60, 8'h4D);
        wr(1'b1, 8'h66, 8'h08);
        wr(1'b0, 8'h60, 8'h5A);
        settle(1);
        chk("irq on data write", 24'h000001, {23'h0, keyboardIrq});
        rd(1'b0, 8'h60, 8'h5A);
        wr(1'b0, 8'h61, 8'h80);
        settle(1);
        chk("irq cleared", 24'h000000, {23'h0, keyboardIrq});
        rd(1'b0, 8'h61, 8'h80);
    endtask

    // ************************************************************
    // sequence and hang guard
    // ************************************************************
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        settle(3);
        tReset();
        tDrive();
        tSense();
        tKeyFull();
        tPartial();
        tTimer();
        tData();
        results();
    end
endmodule // testbench

// ### verilog/kms_sync.sv
// keyboard matrix scanner: two-flop synchroniser, one chain per bit
// assumes the inputs may change at any time relative to clock

`timescale 1ns/1ps

module kms_sync #(
    parameter int WIDTH = 24
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    // the first stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : gChain
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                stage1_r[i] <= 1'b1;
                stage2_r[i] <= 1'b1;
            end else begin
                stage1_r[i] <= asyncIn[i];
                stage2_r[i] <= stage1_r[i];
            end
        end
    end

    assign syncOut = stage2_r;

endmodule // kms_sync

// ### verilog/kms_timer.sv
// keyboard matrix scanner: periodic scan timer
// assumes period is static while enabled; a change is compared against the running count at once

`timescale 1ns/1ps

module kms_timer #(
    parameter int TICK_CYCLES = kms_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic [7:0] period,
    output logic tick
);

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_r;
    logic [7:0] count_r;
    logic tick_r;
    wire preWrap = (pre_r == PRE_LAST);
    wire countWrap = preWrap && (count_r == period);

    // disabling clears both stages so the first tick is a full period away
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_r <= '0;
            count_r <= 8'h00;
            tick_r <= 1'b0;
        end else if (!enable) begin
            pre_r <= '0;
            count_r <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            pre_r <= preWrap ? '0 : pre_r + PW'(1);
            count_r <= countWrap ? 8'h00 : (preWrap ? count_r + 8'h01 : count_r);
            tick_r <= countWrap;
        end
    end

    assign tick = tick_r;

endmodule // kms_timer

// ### verilog/kms_top.sv
// keyboard matrix scanner: scan drive, return sense, scan interrupts, keyboard data port
// assumes pin assignment is decided outside (scanSel, returnSel) and pins are resolved
// by the surrounding pad logic from pinOut and pinOeN

`timescale 1ns/1ps

module kms_top #(
    parameter int TICK_CYCLES = kms_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ioIndex,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioWrData,
    input wire logic ioWr,
    input wire logic ioRd,
    output logic [7:0] ioRdData,
    output logic ioRdValid,
    input wire logic [23:0] scanSel,
    input wire logic [23:0] returnSel,
    input wire logic [23:0] pinIn,
    output logic [23:0] pinOut,
    output logic [23:0] pinOeN,
    input wire logic [7:0] serialData,
    input wire logic [7:0] auxIn,
    output logic nmi,
    output logic keyboardIrq
);

    // ********************************************************
    // address decode
    // ********************************************************
    function automatic logic hit(input logic idx, input logic [7:0] addr,
                                 input logic wantIdx, input logic [7:0] want);
        return (idx == wantIdx) && (addr == want);
    endfunction

    wire hitData = hit(ioIndex, ioAddr, 1'b0, kms_pkg::ADDR_KBD_DATA);
    wire hitCtrl = hit(ioIndex, ioAddr, 1'b0, kms_pkg::ADDR_KBD_CTRL);
    wire hitAux = hit(ioIndex, ioAddr, 1'b0, kms_pkg::ADDR_KBD_AUX);
    wire hitScanEn = hit(ioIndex, ioAddr, 1'b1, kms_pkg::IDX_SCAN_ENABLE);
    wire hitNmi = hit(ioIndex, ioAddr, 1'b1, kms_pkg::IDX_NMI_CTRL_STAT);
    wire hitPeriod = hit(ioIndex, ioAddr, 1'b1, kms_pkg::IDX_TIMER_PERIOD);
    // group A sense read, watched by the cover below
    wire hitSense0 = hit(ioIndex, ioAddr, 1'b1, kms_pkg::IDX_SENSE_BASE);

    // ********************************************************
    // state
    // ********************************************************
    logic [7:0] scanEn_r;
    logic [7:0] ctrl_r;
    logic [7:0] kbdData_r;
    logic [7:0] period_r;
    logic [7:0] drive_r [0:2];
    logic keyEn_r;
    logic timerEn_r;
    logic keySts_r;
    logic timerSts_r;
    logic keyPrev_r;
    logic kbdIrq_r;
    logic nmi_r;
    logic [23:0] pinOeN_r;
    logic [23:0] pinOut_r;
    logic [7:0] rdData_r;
    logic rdValid_r;

    logic [23:0] driveVec;
    logic [23:0] pinSync;
    logic [7:0] grpRead [0:2];
    logic [2:0] grpHit;
    logic timerTick;

    // ********************************************************
    // pin sampling
    // ********************************************************
    kms_sync #(.WIDTH(kms_pkg::NUM_PINS)) uSync (
        .clock(clock),
        .rst(rst),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    wire partialMode = scanEn_r[kms_pkg::MODE_SELECT_BIT];
    wire matrixPrimary = scanEn_r[kms_pkg::PRIMARY_SELECT_BIT];

    // non-return pins read high so software can mask sparse layouts cheaply
    wire [23:0] senseView = pinSync | ~returnSel;

    // ********************************************************
    // drive and sense groups
    // ********************************************************
    for (genvar g = 0; g < kms_pkg::NUM_GROUPS; g++) begin : gGroup
        wire hitDrive = hit(ioIndex, ioAddr, 1'b1, kms_pkg::IDX_DRIVE_BASE + 8'(g));
        wire hitSense = hit(ioIndex, ioAddr, 1'b1, kms_pkg::IDX_SENSE_BASE + 8'(g));
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                drive_r[g] <= kms_pkg::DRIVE_RST;
            end else if (ioWr && hitDrive) begin
                drive_r[g] <= ioWrData;
            end
        end
        assign driveVec[g*8 +: 8] = drive_r[g];
        assign grpHit[g] = hitDrive || hitSense;
        assign grpRead[g] = (hitDrive ? drive_r[g] : 8'h00) |
                            (hitSense ? senseView[g*8 +: 8] : 8'h00);
    end

    // ********************************************************
    // key detection
    // ********************************************************
    // full mode only counts a press while every scan pin is driving low
    wire allDriven = (|scanSel) && ((scanSel & ~driveVec) == 24'h000000);
    wire fullKey = allDriven && (|(returnSel & ~pinSync));
    // partial mode: return status comes from the external buffer, so only scan pins matter
    wire partialKey = |(scanSel & pinSync);
    wire keyNow = partialMode ? partialKey : fullKey;
    wire keyEdge = keyNow && !keyPrev_r;
    wire keySet = keyEdge && keyEn_r;

    // ********************************************************
    // periodic timer
    // ********************************************************
    kms_timer #(.TICK_CYCLES(TICK_CYCLES)) uTimer (
        .clock(clock),
        .rst(rst),
        .enable(timerEn_r),
        .period(period_r),
        .tick(timerTick)
    );

    // ********************************************************
    // control and status next values
    // ********************************************************
    wire nmiWr = ioWr && hitNmi;
    wire keyClr = nmiWr && ioWrData[kms_pkg::KEY_NMI_STS_BIT];
    wire timerClr = nmiWr && ioWrData[kms_pkg::TIMER_NMI_STS_BIT];
    // an event in the clearing cycle survives the clear
    wire keySts_nxt = keySet || (keySts_r && !keyClr);
    wire timerSts_nxt = timerTick || (timerSts_r && !timerClr);

    wire dataWr = ioWr && hitData && matrixPrimary;
    wire irqClr = ioWr && hitCtrl && ioWrData[kms_pkg::KBD_IRQ_CLEAR_BIT];
    wire kbdIrq_nxt = dataWr || (kbdIrq_r && !irqClr);

    logic [7:0] nmiView;
    always_comb begin
        nmiView = 8'h00;
        nmiView[kms_pkg::KEY_NMI_EN_BIT] = keyEn_r;
        nmiView[kms_pkg::TIMER_EN_BIT] = timerEn_r;
        nmiView[kms_pkg::KEY_NMI_STS_BIT] = keySts_r;
        nmiView[kms_pkg::TIMER_NMI_STS_BIT] = timerSts_r;
    end

    // serial shift data is shown when the serial side is primary
    wire [7:0] dataView = matrixPrimary ? kbdData_r : serialData;
    wire [7:0] grpMux = grpRead[0] | grpRead[1] | grpRead[2];
    wire [7:0] rdMux = hitData ? dataView :
                       hitCtrl ? ctrl_r :
                       hitAux ? auxIn :
                       hitScanEn ? scanEn_r :
                       hitNmi ? nmiView :
                       hitPeriod ? period_r :
                       (|grpHit) ? grpMux : kms_pkg::UNMAPPED_READ;

    // only assigned scan pins ever drive; the level is always low
    wire [23:0] pinOeN_nxt = ~(scanSel & driveVec);

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scanEn_r <= kms_pkg::SCAN_ENABLE_RST;
            ctrl_r <= kms_pkg::KBD_CTRL_RST;
            period_r <= kms_pkg::TIMER_PERIOD_RST;
        end else begin
            if (ioWr && hitScanEn) scanEn_r <= ioWrData;
            if (ioWr && hitCtrl) ctrl_r <= ioWrData;
            if (ioWr && hitPeriod) period_r <= ioWrData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keyEn_r <= 1'b0;
            timerEn_r <= 1'b0;
            keySts_r <= 1'b0;
            timerSts_r <= 1'b0;
            keyPrev_r <= 1'b0;
            nmi_r <= 1'b0;
        end else begin
            if (nmiWr) keyEn_r <= ioWrData[kms_pkg::KEY_NMI_EN_BIT];
            if (nmiWr) timerEn_r <= ioWrData[kms_pkg::TIMER_EN_BIT];
            keySts_r <= keySts_nxt;
            timerSts_r <= timerSts_nxt;
            keyPrev_r <= keyNow;
            nmi_r <= keySts_r || timerSts_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            kbdData_r <= kms_pkg::KBD_DATA_RST;
            kbdIrq_r <= 1'b0;
        end else begin
            if (dataWr) kbdData_r <= ioWrData;
            kbdIrq_r <= kbdIrq_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinOeN_r <= 24'hFFFFFF;
            pinOut_r <= 24'h000000;
            rdData_r <= 8'h00;
            rdValid_r <= 1'b0;
        end else begin
            pinOeN_r <= pinOeN_nxt;
            pinOut_r <= 24'h000000;
            rdData_r <= ioRd ? rdMux : rdData_r;
            rdValid_r <= ioRd;
        end
    end

    assign ioRdData = rdData_r;
    assign ioRdValid = rdValid_r;
    assign pinOut = pinOut_r;
    assign pinOeN = pinOeN_r;
    assign nmi = nmi_r;
    assign keyboardIrq = kbdIrq_r;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_nonscan_pins_float: assert property (
        ##1 ((pinOeN_r | $past(scanSel)) == 24'hFFFFFF))
        else $error("non-scan pin is being driven");

    a_scan_drive_low: assert property (
        (ioWr && ioIndex && ioAddr == kms_pkg::IDX_DRIVE_BASE + 8'h01 && ioWrData[0]
        && scanSel[8]) ##1 scanSel[8] |=> !pinOeN_r[8] && !pinOut_r[8])
        else $error("scan pin not driven low after drive bit set");

    a_sense_reads_one: assert property (
        (ioRd && ioIndex && ioAddr == kms_pkg::IDX_SENSE_BASE)
        |=> ioRdValid && ((ioRdData | $past(returnSel[7:0])) == 8'hFF))
        else $error("non-return sense bit read low");

    a_full_key_nmi: assert property (
        (!partialMode && keyEn_r && fullKey && !keyPrev_r) |=> keySts_r ##1 nmi)
        else $error("full mode key press gave no interrupt");

    a_partial_key_nmi: assert property (
        (partialMode && keyEn_r && partialKey && !keyPrev_r) |=> keySts_r ##1 nmi)
        else $error("partial mode key press gave no interrupt");

    a_timer_nmi_raise: assert property (
        timerTick |=> timerSts_r ##1 nmi)
        else $error("timer tick gave no interrupt");

    a_mode_bit_taken: assert property (
        (ioWr && hitScanEn) |=> partialMode == $past(ioWrData[2]))
        else $error("mode select not taken from bit two");

    a_data_write_irq: assert property (
        (ioWr && hitData && matrixPrimary) |=> keyboardIrq [*2])
        else $error("data port write did not raise keyboard interrupt");

    a_serial_primary_quiet: assert property (
        (!kbdIrq_r && !(ioWr && hitData && matrixPrimary)) |=> !keyboardIrq)
        else $error("keyboard interrupt raised without a matrix data write");

    a_status_set_wins: assert property (
        (keySet && keyClr) |=> keySts_r)
        else $error("key event lost to a clear");

    // an enabled pad may only ever pull low, never drive high
    a_pin_level_low: assert property (
        ((~pinOeN_r) & pinOut_r) == 24'h000000)
        else $error("driven pin not driven low");

    a_sense_live_level: assert property (
        (ioRd && ioIndex && ioAddr == kms_pkg::IDX_SENSE_BASE)
        |=> ((ioRdData ^ $past(pinSync[7:0])) & $past(returnSel[7:0])) == 8'h00)
        else $error("return bit did not read the sampled pin level");

    // the first two edges after reset still show the synchroniser's reset ones
    a_sync_two_stage: assert property (
        (!$past(rst) && !$past(rst, 2)) |-> pinSync == $past(pinIn, 2))
        else $error("pin sample did not pass exactly two flops");

    a_timer_off_quiet: assert property (
        !timerEn_r |=> !timerTick)
        else $error("timer ticked while disabled");

    a_key_status_clear: assert property (
        (keyClr && !keySet) |=> !keySts_r)
        else $error("key status not cleared by write");

    a_irq_clear_write: assert property (
        (irqClr && !dataWr) |=> !keyboardIrq)
        else $error("keyboard interrupt not cleared");

    a_serial_data_read: assert property (
        (ioRd && hitData && !matrixPrimary) |=> ioRdData == $past(serialData))
        else $error("serial code not shown while serial side is primary");

    c_full_scan_press: cover property (!partialMode && keySet);
    c_partial_scan_press: cover property (partialMode && keySet);
    c_timer_period: cover property (timerTick ##[1:300] timerTick);
    c_data_then_ack: cover property (dataWr ##[1:20] irqClr);
    c_return_low_read: cover property (ioRd && hitSense0 && !(&senseView[7:0]));

endmodule // kms_top
